// ---- hdl/zts_array.sv ----
// Storage array with per-lane write and combinational read.
`timescale 1ns/1ps
`include "zts_defs.svh"
module zts_array #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 36
) (
  input wire logic clock,
  zts_mem_if.store mem
);
  localparam int LW = `ZTS_LANE_W;
  localparam int LANES = DATA_W / LW;
  localparam int DEPTH = 1 << ADDR_W;

  // The array has no reset, so contents survive reset and snooze alike.
  logic [DATA_W-1:0] ram [DEPTH];

  // Read is combinational so the caller can register it at the edge.
  assign mem.rdata = ram[mem.raddr];

  // Only lanes whose enable is low are written; the rest keep old data.
  always_ff @(posedge clock)
  begin
    if (mem.we)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!mem.laneN[i])
        begin
          ram[mem.waddr][i*LW +: LW] <= mem.wdata[i*LW +: LW]; // [R18]
        end
      end
    end
  end
endmodule

// ---- hdl/zts_burst_ctr.sv ----
// Two-bit burst address counter with linear and interleaved order.
`timescale 1ns/1ps
`include "zts_defs.svh"
module zts_burst_ctr (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic step,
  input wire logic load,
  input wire logic linear,
  input wire logic [`ZTS_CNT_W-1:0] startLsb,
  output logic [`ZTS_CNT_W-1:0] effLsb
);
  logic [`ZTS_CNT_W-1:0] start_q;
  logic [`ZTS_CNT_W-1:0] start_d;
  logic [`ZTS_CNT_W-1:0] cnt_q;
  logic [`ZTS_CNT_W-1:0] cnt_d;
  logic [`ZTS_CNT_W-1:0] nextCnt;

  // Two-bit arithmetic wraps by itself inside the four-word group.
  always_comb
  begin
    nextCnt = cnt_q + `ZTS_CNT_ONE;
    start_d = start_q;
    cnt_d = cnt_q;
    if (load)
      effLsb = startLsb; // [R6]
    else if (linear)
      effLsb = start_q + nextCnt; // [R19]
    else
      effLsb = start_q ^ nextCnt; // [R19]
    if (step && load)
    begin
      start_d = startLsb; // [R5]
      cnt_d = `ZTS_CNT_ZERO;
    end
    else if (step)
      cnt_d = nextCnt; // [R4]
  end

  // Count state.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q <= `ZTS_CNT_ZERO;
      cnt_q <= `ZTS_CNT_ZERO;
    end
    else
    begin
      start_q <= start_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seqLoad;
    step && load;
  endsequence

  sequence seqLinAdv;
    step && !load && linear;
  endsequence

  AST_LINEAR_FIRST: assert property ( // [R5]
    seqLoad ##1 seqLinAdv |-> effLsb == $past(startLsb) + `ZTS_CNT_ONE)
    else $error("linear burst did not start one above the seed");

  AST_INTERLEAVE_FIRST: assert property ( // [R16]
    seqLoad ##1 (step && !load && !linear)
    |-> effLsb == ($past(startLsb) ^ `ZTS_CNT_ONE))
    else $error("interleaved burst did not flip the low bit");

  AST_LINEAR_WRAP: assert property ( // [R19]
    seqLoad ##1 seqLinAdv [*4] |-> effLsb == $past(startLsb, 4))
    else $error("linear burst did not wrap after four beats");
endmodule

// ---- hdl/zts_defs.svh ----
// Constants shared by the synchronous SRAM port and its submodules.
// What this block does
// (R1) Array is 1M x 18 or 512K x 36; address width follows the choice.
// (R2) Address, data, selects, lane enables and load/advance are taken on edges.
// (R3) Load/advance low at an edge loads a new address and starts a cycle.
// (R4) Load/advance high steps the burst counter; read/write select is ignored.
// (R5) Burst counter is two bits, seeded from the two lowest loaded address bits.
// (R6) Two lowest loaded address bits are the burst start address.
// (R7) Read or write is fixed only at a load; controller chooses it there.
// (R8) Read/write select low at a load means write; array write is self-timed.
// (R9) Controller gives lane enables with the address; they apply to later data.
// (R10) Enable one gates lane a up to four for lane d; x18 uses two.
// (R11) Chip selects are sampled only on loads, ignored on advance cycles.
// (R12) Selected only when primary low, second low and high select high.
// (R13) Clock gate high: edges ignored, all state and outputs hold.
// (R14) Output enable low turns data drivers on, independent of the clock.
// (R15) Reads and writes alternate back to back with no idle cycles.
// (R16) Burst order low selects linear, high selects interleaved; kept static.
// (R17) Snooze high: standby, contents kept, all other inputs ignored.
// (R18) All lane enables low writes the full word; others keep unselected lanes.
// (R19) Burst wraps in four words: linear adds modulo four, interleaved XORs.
// (R20) Read data is driven in the cycle after its registering edge.
// (R21) Deselected cycle floats the data outputs and touches no array word.
`ifndef ZTS_DEFS_SVH
`define ZTS_DEFS_SVH
`define ZTS_LANE_W 9
`define ZTS_X18_DATA_W 18
`define ZTS_X18_ADDR_W 20
`define ZTS_X36_DATA_W 36
`define ZTS_X36_ADDR_W 19
`define ZTS_CNT_W 2
`define ZTS_CNT_ZERO 2'h0
`define ZTS_CNT_ONE 2'h1
`endif

// ---- hdl/zts_mem_if.sv ----
// Array access bundle between the port control and the storage array.
`timescale 1ns/1ps
interface zts_mem_if #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 36,
  parameter int LANES = 4
);
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [LANES-1:0] laneN;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;

  // Control end drives the write and read address.
  modport ctrl (
    output we,
    output waddr,
    output wdata,
    output laneN,
    output raddr,
    input rdata
  );

  // Storage end answers the read and takes the write.
  modport store (
    input we,
    input waddr,
    input wdata,
    input laneN,
    input raddr,
    output rdata
  );
endinterface

// ---- hdl/zts_pkg.sv ----
// Types shared by the synchronous SRAM port.
package zts_pkg;
  // Kind of the cycle last loaded; Gray steps idle, read, write.
  typedef enum logic [1:0] {
    ZTS_IDLE = 2'h0,
    ZTS_READ = 2'h1,
    ZTS_WRITE = 2'h3
  } zts_cycle_e;
endpackage

// ---- hdl/zts_sram_port.sv ----
// Top of the synchronous flow-through SRAM port with zero turnaround.
`timescale 1ns/1ps
`include "zts_defs.svh"
module zts_sram_port #(
  parameter int ADDR_W = `ZTS_X36_ADDR_W,
  parameter int DATA_W = `ZTS_X36_DATA_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic chipSelN,
  input wire logic chipSelExpandN,
  input wire logic chipSelExpand,
  input wire logic loadOrAdvance,
  input wire logic readWriteN,
  input wire logic [DATA_W/`ZTS_LANE_W-1:0] laneWriteEnN,
  input wire logic clockGateN,
  input wire logic outEnableN,
  input wire logic burstOrder,
  input wire logic snoozeRequest
);
  localparam int LW = `ZTS_LANE_W;
  localparam int LANES = DATA_W / LW;

  // ----------------------------------------------------------------
  // Organisation check
  // ----------------------------------------------------------------

  // Only the two documented shapes have a matching lane and address map.
  if (!((DATA_W == `ZTS_X18_DATA_W && ADDR_W == `ZTS_X18_ADDR_W) ||
        (DATA_W == `ZTS_X36_DATA_W && ADDR_W == `ZTS_X36_ADDR_W)))
  begin : gBadOrg
    $error("organisation must be 1M x 18 or 512K x 36"); // [R1]
  end

  // ----------------------------------------------------------------
  // Edge qualification and cycle decode
  // ----------------------------------------------------------------

  // An edge counts only when the clock gate is low and snooze is off.
  logic enabled;
  logic selected;
  logic isLoad;
  assign enabled = !clockGateN && !snoozeRequest; // [R13] [R17]
  assign isLoad = !loadOrAdvance; // [R3]
  // The three selects only matter on a load edge.
  assign selected = !chipSelN && !chipSelExpandN && chipSelExpand; // [R12]

  // ----------------------------------------------------------------
  // Burst addressing
  // ----------------------------------------------------------------

  logic [`ZTS_CNT_W-1:0] effLsb;
  logic [ADDR_W-1:0] effAddr;
  logic [ADDR_W-3:0] baseHi_q;
  logic [ADDR_W-3:0] baseHi_d;

  // Burst order is sampled live; it is expected to stay static.
  zts_burst_ctr uCtr (
    .clock(clock),
    .rst_n(rst_n),
    .step(enabled),
    .load(isLoad),
    .linear(!burstOrder), // [R16]
    .startLsb(addr[`ZTS_CNT_W-1:0]),
    .effLsb(effLsb)
  );

  // On a load the pin address is used directly; on advance the upper
  // bits are the stored base and the low bits come from the counter.
  assign effAddr = isLoad ? addr : {baseHi_q, effLsb}; // [R3] [R4]

  // ----------------------------------------------------------------
  // Array access
  // ----------------------------------------------------------------

  zts_mem_if #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANES(LANES)
  ) mem ();

  zts_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) uArray (
    .clock(clock),
    .mem(mem.store)
  );

  zts_pkg::zts_cycle_e kind_q;
  zts_pkg::zts_cycle_e kind_d;
  logic pendWrite_q;
  logic pendWrite_d;
  logic [ADDR_W-1:0] wAddr_q;
  logic [ADDR_W-1:0] wAddr_d;
  logic [LANES-1:0] wLaneN_q;
  logic [LANES-1:0] wLaneN_d;
  logic drive_q;
  logic drive_d;
  logic [DATA_W-1:0] dataOut_q;
  logic [DATA_W-1:0] dataOut_d;
  logic [DATA_W-1:0] fwdWord;
  logic hit;

  // Write data trails its address by one edge, so the write lands on
  // the edge after the address edge, with no strobe from outside.
  assign mem.we = pendWrite_q && enabled; // [R8]
  assign mem.waddr = wAddr_q;
  assign mem.wdata = dataIn; // [R2]
  assign mem.laneN = wLaneN_q; // [R9] [R10]
  assign mem.raddr = effAddr;

  // A read of the word being written on the same edge sees new lanes.
  // Without this bypass a read right after a write would return stale
  // data and break zero-turnaround operation.
  assign hit = pendWrite_q && (wAddr_q == effAddr);

  for (genvar i = 0; i < LANES; i++)
  begin : gFwd
    assign fwdWord[i*LW +: LW] = (hit && !wLaneN_q[i]) ?
      dataIn[i*LW +: LW] : mem.rdata[i*LW +: LW]; // [R15] [R18]
  end

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------

  // Next cycle kind, pending write and output word.
  always_comb
  begin
    kind_d = kind_q;
    baseHi_d = baseHi_q;
    pendWrite_d = pendWrite_q;
    wAddr_d = wAddr_q;
    wLaneN_d = wLaneN_q;
    drive_d = drive_q;
    dataOut_d = dataOut_q;
    if (enabled)
    begin
      if (isLoad)
      begin
        baseHi_d = addr[ADDR_W-1:`ZTS_CNT_W]; // [R3]
        if (!selected) // [R11]
          kind_d = zts_pkg::ZTS_IDLE; // [R21]
        else if (readWriteN)
          kind_d = zts_pkg::ZTS_READ; // [R7]
        else
          kind_d = zts_pkg::ZTS_WRITE; // [R7] [R8]
      end
      // On advance the kind and selection carry over unchanged.
      pendWrite_d = 1'b0;
      drive_d = 1'b0;
      unique case (kind_d)
        zts_pkg::ZTS_READ:
        begin
          drive_d = 1'b1; // [R20]
          dataOut_d = fwdWord; // [R20]
        end
        zts_pkg::ZTS_WRITE:
        begin
          pendWrite_d = 1'b1;
          wAddr_d = effAddr;
          wLaneN_d = laneWriteEnN; // [R9]
        end
        zts_pkg::ZTS_IDLE:
        begin
          drive_d = 1'b0; // [R21]
        end
        default:
        begin
          drive_d = 1'b0;
        end
      endcase
    end
  end

  // Register stage; holding _d at _q models a suspended clock.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kind_q <= zts_pkg::ZTS_IDLE;
      baseHi_q <= '0;
      pendWrite_q <= 1'b0;
      wAddr_q <= '0;
      wLaneN_q <= '1;
      drive_q <= 1'b0;
      dataOut_q <= '0;
    end
    else
    begin
      kind_q <= kind_d;
      baseHi_q <= baseHi_d;
      pendWrite_q <= pendWrite_d;
      wAddr_q <= wAddr_d;
      wLaneN_q <= wLaneN_d;
      drive_q <= drive_d;
      dataOut_q <= dataOut_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------

  // Output enable and snooze act without the clock, so the driver
  // enable is the only output that is not purely a flip-flop.
  assign dataOut = dataOut_q;
  assign dataOe = drive_q && !outEnableN && !snoozeRequest; // [R14] [R17]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seqReadLoad;
    enabled && isLoad && selected && readWriteN;
  endsequence

  sequence seqWriteLoad;
    enabled && isLoad && selected && !readWriteN;
  endsequence

  AST_READ_NEXT_CYCLE: assert property ( // [R20]
    seqReadLoad |=> drive_q && dataOut_q == $past(fwdWord))
    else $error("read data not presented after its edge");

  AST_WRITE_SELF_TIMED: assert property ( // [R8]
    seqWriteLoad ##1 enabled |-> mem.we && mem.waddr == $past(addr))
    else $error("write did not reach the loaded address");

  AST_LANES_WITH_ADDR: assert property ( // [R9]
    seqWriteLoad ##1 enabled |-> mem.laneN == $past(laneWriteEnN))
    else $error("lane enables not taken with the address");

  AST_BACK_TO_BACK: assert property ( // [R15]
    seqWriteLoad ##1 seqReadLoad |-> mem.we ##1 drive_q)
    else $error("read after write was stalled");

  AST_ADVANCE_KEEPS_KIND: assert property ( // [R4]
    enabled && !isLoad |=> kind_q == $past(kind_q))
    else $error("advance changed the cycle kind");

  AST_SELECTS_IGNORED: assert property ( // [R11]
    enabled && !isLoad && kind_q == zts_pkg::ZTS_READ |=> drive_q)
    else $error("selects acted during a burst advance");

  AST_DESELECT_FLOAT: assert property ( // [R21]
    enabled && isLoad && !selected |=> !drive_q && !pendWrite_q)
    else $error("deselected cycle drove data or wrote");

  AST_GATE_HOLDS: assert property ( // [R13]
    !enabled |=> $stable(dataOut_q) && $stable(kind_q) && $stable(drive_q))
    else $error("state moved on a gated edge");

  AST_OE_OFF: assert property ( // [R14]
    outEnableN |-> !dataOe)
    else $error("drivers on with output enable high");

  AST_SNOOZE_QUIET: assert property ( // [R17]
    snoozeRequest |-> !dataOe && !mem.we)
    else $error("activity during snooze");
endmodule

// ---- verif/test_zero_turnaround_sync_sram_port.sv ----
// Self-checking bench for the synchronous flow-through SRAM port.
`timescale 1ns/1ps
module test_zero_turnaround_sync_sram_port;
  localparam int AW = 19;
  localparam int DW = 36;
  localparam logic LD = 1'b0;
  localparam logic AD = 1'b1;
  localparam logic RD = 1'b1;
  localparam logic WR = 1'b0;
  localparam logic [3:0] ALL = 4'h0;
  localparam logic [3:0] NONE = 4'hf;
  localparam logic [18:0] WADDR = 19'h00040;
  localparam logic [18:0] BASE = 19'h00100;
  localparam logic [35:0] D1 = 36'h1_2345_6789;
  localparam logic [35:0] D2 = 36'hf_edcb_a987;
  localparam logic [35:0] LANES_AC = 36'h0_07fc_01ff;
  localparam logic [35:0] PAT = 36'h5_a5a5_a500;

  // --------------------------------------------------------------------
  // Bus, design and clock
  // --------------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] addr;
  logic [DW-1:0] dataIn;
  logic [DW-1:0] dataOut;
  logic dataOe;
  logic chipSelN;
  logic chipSelExpandN;
  logic chipSelExpand;
  logic loadOrAdvance;
  logic readWriteN;
  logic [3:0] laneWriteEnN;
  logic clockGateN;
  logic outEnableN = 1'b0;
  logic burstOrder = 1'b0;
  logic snoozeRequest = 1'b0;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [DW-1:0] aWord;

  zts_host_model #(.ADDR_W(AW), .DATA_W(DW)) host (.clock(clock),
    .addr(addr), .dataIn(dataIn), .chipSelN(chipSelN),
    .chipSelExpandN(chipSelExpandN), .chipSelExpand(chipSelExpand),
    .loadOrAdvance(loadOrAdvance), .readWriteN(readWriteN),
    .laneWriteEnN(laneWriteEnN), .clockGateN(clockGateN));

  zts_sram_port #(.ADDR_W(AW), .DATA_W(DW)) uut (.clock(clock),
    .rst_n(rst_n), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .chipSelN(chipSelN),
    .chipSelExpandN(chipSelExpandN), .chipSelExpand(chipSelExpand),
    .loadOrAdvance(loadOrAdvance), .readWriteN(readWriteN),
    .laneWriteEnN(laneWriteEnN), .clockGateN(clockGateN),
    .outEnableN(outEnableN), .burstOrder(burstOrder),
    .snoozeRequest(snoozeRequest));

  // 25 MHz clock.
  always #20 clock = ~clock;

  // The whole run needs about sixty cycles; a hang is cut well above.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk_word(input string what, input logic [DW-1:0] exp,
    input logic [DW-1:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Full write, lane write, then a read of the same word right behind it.
  task automatic s_lanes;
    aWord = (D2 & LANES_AC) | (D1 & ~LANES_AC);
    host.beat(LD, WR, WADDR, ALL, '0, 1'b0);
    host.beat(LD, WR, WADDR, 4'ha, D1, 1'b1);
    host.beat(LD, RD, WADDR, NONE, D2, 1'b1);
    host.beat(AD, WR, '0, NONE, '0, 1'b0);
    chk_word("bypass_read", aWord, dataOut);
    host.beat(LD, RD, WADDR, NONE, '0, 1'b0);
    chk_bit("advance_keeps_read", 1'b1, dataOe);
    host.beat(AD, RD, '0, NONE, '0, 1'b0);
    chk_word("stored_read", aWord, dataOut);
  endtask

  // Burst write from an aligned base, burst read starting at offset one,
  // where linear and interleaved orders visit the words differently.
  task automatic s_burst(input logic ord);
    logic [1:0] lsb;
    @(posedge clock);
    burstOrder <= ord;
    host.beat(LD, WR, BASE, ALL, '0, 1'b0);
    for (int k = 0; k < 3; k++)
      host.beat(AD, RD, '0, ALL, PAT + 36'(k), 1'b1);
    host.beat(LD, RD, BASE + 19'h1, NONE, PAT + 36'h3, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      host.beat(AD, WR, '0, NONE, '0, 1'b0);
      lsb = ord ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
      chk_word("burst_word", PAT + 36'(lsb), dataOut);
    end
  endtask

  // Each select off in turn; advances must not wake a deselected cycle.
  task automatic s_deselect;
    logic [2:0] off [3] = '{3'h5, 3'h3, 3'h0};
    for (int i = 0; i < 3; i++)
    begin
      host.sel = off[i];
      host.beat(LD, RD, WADDR, NONE, '0, 1'b0);
      host.sel = 3'h1;
      host.beat(AD, RD, '0, NONE, '0, 1'b0);
      chk_bit("deselect_oe", 1'b0, dataOe);
      host.beat(AD, RD, '0, NONE, '0, 1'b0);
      chk_bit("advance_deselect_oe", 1'b0, dataOe);
    end
    host.sel = 3'h0;
    host.beat(LD, WR, WADDR, ALL, '0, 1'b0);
    host.sel = 3'h1;
    host.beat(LD, RD, WADDR, NONE, ~aWord, 1'b1);
    host.beat(AD, RD, '0, NONE, '0, 1'b0);
    chk_word("deselect_no_write", aWord, dataOut);
  endtask

  // Gated edges must hold the read output although a new load is offered.
  task automatic s_gate;
    host.beat(LD, RD, WADDR, NONE, '0, 1'b0);
    host.gate = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      host.beat(LD, RD, BASE, NONE, '0, 1'b0);
      chk_word("gated_hold", aWord, dataOut);
    end
    host.gate = 1'b0;
    host.beat(LD, RD, BASE, NONE, '0, 1'b0);
    host.beat(AD, RD, '0, NONE, '0, 1'b0);
    chk_word("ungated_read", PAT, dataOut);
  endtask

  // Output enable and snooze; a write offered in snooze must be lost.
  task automatic s_async;
    host.beat(LD, RD, BASE, NONE, '0, 1'b0);
    host.beat(AD, RD, '0, NONE, '0, 1'b0);
    @(posedge clock);
    outEnableN <= 1'b1;
    #1;
    chk_bit("oe_off", 1'b0, dataOe);
    @(posedge clock);
    outEnableN <= 1'b0;
    #1;
    chk_bit("oe_on", 1'b1, dataOe);
    @(posedge clock);
    snoozeRequest <= 1'b1;
    #1;
    chk_bit("snooze_oe", 1'b0, dataOe);
    host.beat(LD, WR, BASE, ALL, '0, 1'b0);
    host.beat(LD, RD, BASE, NONE, ~PAT, 1'b1);
    @(posedge clock);
    snoozeRequest <= 1'b0;
    host.beat(LD, RD, BASE, NONE, '0, 1'b0);
    host.beat(AD, RD, '0, NONE, '0, 1'b0);
    chk_word("snooze_kept", PAT, dataOut);
  endtask

  // Reset for three cycles, then every scenario in turn.
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk_bit("reset_oe", 1'b0, dataOe);
    s_lanes();
    s_burst(1'b0);
    s_burst(1'b1);
    s_deselect();
    s_gate();
    s_async();
    print_verdict();
  end
endmodule

// ---- verif/zts_host_model.sv ----
// Memory controller model that drives the bus of the SRAM port.
`timescale 1ns/1ps
`include "zts_defs.svh"
module zts_host_model #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 36
) (
  input wire logic clock,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dataIn,
  output logic chipSelN,
  output logic chipSelExpandN,
  output logic chipSelExpand,
  output logic loadOrAdvance,
  output logic readWriteN,
  output logic [DATA_W/`ZTS_LANE_W-1:0] laneWriteEnN,
  output logic clockGateN
);
  // Selects {primary, second, high} and clock gate for the next beat.
  logic [2:0] sel = 3'h1;
  logic gate = 1'b0;

  // Quiet bus at time zero: selected, advancing, clock enabled.
  initial
  begin
    addr = '0;
    dataIn = '0;
    {chipSelN, chipSelExpandN, chipSelExpand} = 3'h1;
    loadOrAdvance = 1'b1;
    readWriteN = 1'b1;
    laneWriteEnN = '1;
    clockGateN = 1'b0;
  end

  // --------------------------------------------------------------------
  // One bus cycle
  // --------------------------------------------------------------------
  // Everything changes just after an edge and holds for a full cycle.
  // Write data rides with the following beat; an idle data bus shows the
  // inverse of its last value so that stale data never looks valid.
  task automatic beat(input logic ld, input logic rw,
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W/`ZTS_LANE_W-1:0] ln,
    input logic [DATA_W-1:0] d, input logic dv);
    @(posedge clock);
    loadOrAdvance <= ld;
    readWriteN <= rw;
    addr <= a;
    laneWriteEnN <= ln;
    {chipSelN, chipSelExpandN, chipSelExpand} <= sel;
    clockGateN <= gate;
    dataIn <= dv ? d : ~dataIn;
    #1;
  endtask
endmodule
